// *** verilog/mtsf_map.svh ***
`ifndef MTSF_MAP_SVH
`define MTSF_MAP_SVH
// Notes on behaviour
// - deferred_flag bit 9 set on first-attempt deferral, cleared by later collisions
// - deferred and late-collision flags clear after status word write-back
// - no_carrier_flag bit 8 set at preamble start, cleared when carrier seen
// - carrier watched from delimiter to last byte; carrier flags never abort
// - in mac loopback no-carrier stays set while receive line is idle
// - carrier_lost_flag bit 7 set when carrier drops or absent during send
// - mac loopback reports carrier_lost_flag set once the send reaches the frame window (delimiter done)
// - sixteenth collision sets excess_collisions_flag bit 6 and aborts
// - collision after 51.2 us from origin sets late_collision_flag bit 5, backs off
// - monitored_bad_flag bit 3 on bad crc, alignment or unmatched source address
// - receive crc checker stays active during transmit
// - with fcs_inhibit set monitored_bad_flag reads low
// - monitored_bad_flag is zero in all loopback modes
// - fifo empty before bus regained sets tx_underrun_flag bit 2 and aborts
// - size mismatch of descriptor sets size_mismatch_flag bit 1 and aborts
// - excessive collisions also set size_mismatch_flag
// - tx_ok_flag bit 0 only without excess collisions, excess deferral, underrun, mismatch
// - control bit 14 picks late window origin: 0 after delimiter, 1 from preamble start
// - control bit 13 clear appends 4-byte fcs, set omits it
// - excess_deferral_flag bit 10 after 3.2 ms deferring, aborts, only if timer enabled
`define MTSF_ADDR_CTRL 4'h0
`define MTSF_ADDR_STAT 4'h1
`define MTSF_ADDR_WB 4'h2
`define MTSF_BIT_OK 0
`define MTSF_BIT_BCM 1
`define MTSF_BIT_FU 2
`define MTSF_BIT_MB 3
`define MTSF_BIT_ZERO 4
`define MTSF_BIT_LC 5
`define MTSF_BIT_EXC 6
`define MTSF_BIT_CL 7
`define MTSF_BIT_NC 8
`define MTSF_BIT_DEF 9
`define MTSF_BIT_EXD 10
`define MTSF_BIT_DEFERRAL_TIMER_DISABLE 12
`define MTSF_BIT_FCSI 13
`define MTSF_BIT_ORG 14
`define MTSF_CTRL_MASK 16'h7000
`define MTSF_CTRL_RST 16'h0000
`define MTSF_CLK_MHZ 50
`define MTSF_SLOT_NS 51200
`define MTSF_SLOT_CYC (`MTSF_SLOT_NS * `MTSF_CLK_MHZ / 1000)
`define MTSF_DEFER_US 3200
`define MTSF_DEFER_CYC (`MTSF_DEFER_US * `MTSF_CLK_MHZ)
`define MTSF_COLL_MAX 16
`endif

// *** verilog/mtsf_pkg.sv ***
package mtsf_pkg;
  typedef enum logic [1:0] {
    MTSF_IDLE,
    MTSF_PREAMBLE,
    MTSF_FRAME,
    MTSF_DONE
  } mtsf_state_t;
endpackage

// *** verilog/mtsf_timer.sv ***
`timescale 1ns/1ns
module mtsf_timer #(
  parameter int W = 18
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic [W-1:0] limit_i,
  output logic expired_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic hit;
  } mtsf_tmr_t;
  mtsf_tmr_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (clear_i) begin
      s_d = '0;
    end else if (run_i && !s_q.hit) begin
      if (s_q.cnt >= limit_i - 1'b1) begin
        s_d.hit = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end
  assign expired_o = s_q.hit;
endmodule

// *** verilog/mtsf_top.sv ***
`timescale 1ns/1ns
`include "mtsf_map.svh"
module mtsf_top
  import mtsf_pkg::*;
#(
  parameter int DEFER_CYCLES = `MTSF_DEFER_CYC,
  parameter int SLOT_CYCLES = `MTSF_SLOT_CYC,
  parameter int COLL_MAX = `MTSF_COLL_MAX
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic mac_loopback_i,
  input wire logic any_loopback_i,
  input wire logic rx_line_active_i,
  input wire logic tx_start_i,
  input wire logic defer_i,
  input wire logic first_attempt_i,
  input wire logic preamble_i,
  input wire logic sfd_done_i,
  input wire logic last_byte_i,
  input wire logic crs_i,
  input wire logic collision_i,
  input wire logic fifo_empty_i,
  input wire logic bus_granted_i,
  input wire logic size_mismatch_i,
  input wire logic mon_valid_i,
  input wire logic mon_crc_bad_i,
  input wire logic mon_align_err_i,
  input wire logic mon_sa_miss_i,
  input wire logic status_written_i,
  output logic abort_o,
  output logic backoff_o,
  output logic append_fcs_o,
  output logic rx_crc_enable_o,
  output logic status_valid_o,
  output logic [15:0] tx_desc_status_word_o
);
  // one width serves both timers, so it must hold the larger limit
  localparam int SW = $clog2((DEFER_CYCLES > SLOT_CYCLES ? DEFER_CYCLES : SLOT_CYCLES) + 1);

  typedef struct packed {
    mtsf_state_t st;
    logic [15:0] ctrl;
    logic deferred_flag;
    logic no_carrier_flag;
    logic carrier_lost_flag;
    logic excess_collisions_flag;
    logic late_collision_flag;
    logic monitored_bad_flag;
    logic tx_underrun_flag;
    logic size_mismatch_flag;
    logic tx_ok_flag;
    logic excess_deferral_flag;
    logic [4:0] coll_cnt;
    logic crs_seen;
    logic origin_open;
    logic late_open;
    logic abort;
    logic backoff;
    logic wb_pending;
    logic [15:0] wb_word;
    logic [15:0] rdata;
  } mtsf_regs_t;

  mtsf_regs_t s_q, s_d;
  logic slot_hit, defer_hit, slot_clr, defer_clr;
  logic [15:0] live_word;

  // slot timer runs only once its origin point has passed
  mtsf_timer #(.W(SW)) u_slot (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(slot_clr),
    .run_i(s_q.origin_open),
    .limit_i(SW'(SLOT_CYCLES)),
    .expired_o(slot_hit)
  );

  mtsf_timer #(.W(SW)) u_defer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(defer_clr),
    .run_i(defer_i && s_q.st == MTSF_IDLE),
    .limit_i(SW'(DEFER_CYCLES)),
    .expired_o(defer_hit)
  );

  always_comb begin
    live_word = '0;
    live_word[`MTSF_BIT_EXD] = s_q.excess_deferral_flag;
    live_word[`MTSF_BIT_DEF] = s_q.deferred_flag;
    live_word[`MTSF_BIT_NC] = s_q.no_carrier_flag;
    live_word[`MTSF_BIT_CL] = s_q.carrier_lost_flag;
    live_word[`MTSF_BIT_EXC] = s_q.excess_collisions_flag;
    live_word[`MTSF_BIT_LC] = s_q.late_collision_flag;
    live_word[`MTSF_BIT_MB] = s_q.monitored_bad_flag;
    live_word[`MTSF_BIT_FU] = s_q.tx_underrun_flag;
    live_word[`MTSF_BIT_BCM] = s_q.size_mismatch_flag;
    live_word[`MTSF_BIT_OK] = s_q.tx_ok_flag;
    live_word = live_word | (s_q.ctrl & `MTSF_CTRL_MASK);
  end

  assign slot_clr = tx_start_i || s_q.st == MTSF_IDLE;
  assign defer_clr = tx_start_i || !defer_i;

  always_comb begin
    s_d = s_q;
    s_d.abort = 1'b0;
    s_d.backoff = 1'b0;
    // register port, read data one cycle after the strobe
    s_d.rdata = '0;
    if (reg_rd_i) begin
      if (reg_addr_i == `MTSF_ADDR_CTRL) begin
        s_d.rdata = live_word;
      end else if (reg_addr_i == `MTSF_ADDR_STAT) begin
        s_d.rdata = {14'h0000, s_q.st};
      end else if (reg_addr_i == `MTSF_ADDR_WB) begin
        s_d.rdata = s_q.wb_word;
      end
    end
    if (reg_wr_i && reg_addr_i == `MTSF_ADDR_CTRL) begin
      s_d.ctrl = reg_wdata_i & `MTSF_CTRL_MASK;
    end
    case (s_q.st)
      MTSF_IDLE: begin
        if (tx_start_i) begin
          s_d.coll_cnt = '0;
          s_d.excess_collisions_flag = 1'b0;
          s_d.late_collision_flag = 1'b0;
          s_d.monitored_bad_flag = 1'b0;
          s_d.tx_underrun_flag = 1'b0;
          s_d.size_mismatch_flag = 1'b0;
          s_d.tx_ok_flag = 1'b0;
          s_d.excess_deferral_flag = 1'b0;
          s_d.carrier_lost_flag = 1'b0;
          s_d.deferred_flag = defer_i && first_attempt_i;
        end else if (defer_i && first_attempt_i) begin
          s_d.deferred_flag = 1'b1;
        end
        if (preamble_i) begin
          s_d.st = MTSF_PREAMBLE;
          s_d.no_carrier_flag = 1'b1;
          s_d.crs_seen = 1'b0;
          s_d.origin_open = s_q.ctrl[`MTSF_BIT_ORG];
        end
        if (size_mismatch_i) begin
          s_d.size_mismatch_flag = 1'b1;
          s_d.abort = 1'b1;
          s_d.st = MTSF_DONE;
        end
      end
      MTSF_PREAMBLE: begin
        if (sfd_done_i) begin
          s_d.st = MTSF_FRAME;
          s_d.origin_open = 1'b1;
        end
      end
      MTSF_FRAME: begin
        // carrier is sampled in the frame window only, and never aborts
        if (crs_i && !(mac_loopback_i && !rx_line_active_i)) begin
          s_d.no_carrier_flag = 1'b0;
          s_d.crs_seen = 1'b1;
        end
        if (!crs_i || mac_loopback_i) begin
          s_d.carrier_lost_flag = 1'b1;
        end
        if (last_byte_i) begin
          s_d.st = MTSF_DONE;
          s_d.tx_ok_flag = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // excess deferral counts only while the timer is enabled; after the state case
    // so that the set wins over a start-of-packet clear in the same cycle
    if (defer_hit && !s_q.ctrl[`MTSF_BIT_DEFERRAL_TIMER_DISABLE] && !s_q.excess_deferral_flag) begin
      s_d.excess_deferral_flag = 1'b1;
      s_d.abort = 1'b1;
      s_d.st = MTSF_DONE;
    end
    if (s_q.st != MTSF_IDLE && s_q.st != MTSF_DONE) begin
      if (collision_i) begin
        s_d.deferred_flag = 1'b0;
        s_d.backoff = 1'b1;
        s_d.st = MTSF_IDLE;
        s_d.origin_open = 1'b0;
        if (slot_hit) begin
          s_d.late_collision_flag = 1'b1;
        end
        s_d.coll_cnt = s_q.coll_cnt + 5'd1;
        if (s_q.coll_cnt == 5'(COLL_MAX - 1)) begin
          s_d.excess_collisions_flag = 1'b1;
          s_d.size_mismatch_flag = 1'b1;
          s_d.abort = 1'b1;
          s_d.backoff = 1'b0;
          s_d.st = MTSF_DONE;
        end
      end else if (fifo_empty_i && !bus_granted_i) begin
        s_d.tx_underrun_flag = 1'b1;
        s_d.abort = 1'b1;
        s_d.st = MTSF_DONE;
      end
    end
    // self-monitoring through the always-on receive checker
    if (mon_valid_i && !any_loopback_i && !s_q.ctrl[`MTSF_BIT_FCSI]) begin
      if (mon_crc_bad_i || mon_align_err_i || mon_sa_miss_i) begin
        s_d.monitored_bad_flag = 1'b1;
      end
    end
    if (s_q.st == MTSF_DONE && !s_q.wb_pending) begin
      if (s_d.excess_collisions_flag || s_d.excess_deferral_flag ||
          s_d.tx_underrun_flag || s_d.size_mismatch_flag) begin
        s_d.tx_ok_flag = 1'b0;
      end
      s_d.wb_word = live_word;
      s_d.wb_word[`MTSF_BIT_OK] = s_d.tx_ok_flag;
      s_d.wb_word[`MTSF_BIT_ZERO] = 1'b0;
      s_d.wb_pending = 1'b1;
    end
    if (s_q.wb_pending && status_written_i) begin
      s_d.wb_pending = 1'b0;
      s_d.st = MTSF_IDLE;
      s_d.deferred_flag = 1'b0;
      s_d.late_collision_flag = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.st <= MTSF_IDLE;
      s_q.ctrl <= `MTSF_CTRL_RST;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign abort_o = s_q.abort;
  assign backoff_o = s_q.backoff;
  assign append_fcs_o = !s_q.ctrl[`MTSF_BIT_FCSI];
  assign rx_crc_enable_o = 1'b1;
  assign status_valid_o = s_q.wb_pending;
  assign tx_desc_status_word_o = s_q.wb_word;
endmodule

// *** verification/mtsf_medium.sv ***
`timescale 1ns/1ns
module mtsf_medium (
  input wire logic clock_i,
  input wire logic carrier_i,
  input wire logic hit_i,
  output logic crs_o,
  output logic collision_o = 1'b0
);
  // carrier echo lags by two clocks, so crs only leads the delimiter in the late-hit packets, which delay it 12 clocks
  logic [1:0] echo_q = 2'h0;
  always @(posedge clock_i) begin
    echo_q <= {echo_q[0], carrier_i};
    collision_o <= hit_i;
  end
  assign crs_o = echo_q[1];
endmodule

// *** verification/mtsf_top_sva.sv ***
`timescale 1ns/1ns
module mtsf_top_sva (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic mac_loopback_i,
  input wire logic any_loopback_i,
  input wire logic abort_o,
  input wire logic backoff_o,
  input wire logic append_fcs_o,
  input wire logic rx_crc_enable_o,
  input wire logic status_valid_o,
  input wire logic [15:0] tx_desc_status_word_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire [15:0] w = tx_desc_status_word_o;
  crc_on_a: assert property (rx_crc_enable_o)
    else $error("rx crc checker off");
  fcs_sel_a: assert property (ce_i && reg_wr_i && reg_addr_i == 4'h0
    |=> append_fcs_o == !$past(reg_wdata_i[13])) else $error("fcs select wrong");
  bit4_zero_a: assert property (!w[4])
    else $error("status bit 4 set");
  ok_clean_a: assert property (status_valid_o && w[0] |-> !(w[10] | w[6] | w[2] | w[1]))
    else $error("ok beside error");
  exc_size_a: assert property (w[6] |-> w[1])
    else $error("excess without mismatch");
  abort_one_a: assert property (abort_o |=> !abort_o)
    else $error("abort too long");
  last_coll_a: assert property (backoff_o |-> !abort_o)
    else $error("backoff with abort");
  mac_lost_a: assert property ($rose(status_valid_o) && mac_loopback_i |-> w[7])
    else $error("loopback carrier lost clear");
  loop_mon_a: assert property ($rose(status_valid_o) && any_loopback_i |-> !w[3])
    else $error("loopback monitored bad");
  fcsi_mon_a: assert property ($rose(status_valid_o) && !append_fcs_o |-> !w[3])
    else $error("inhibit monitored bad");
endmodule
bind mtsf_top mtsf_top_sva u_sva (.*);

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic clock_i = 0, rst_n_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, tx_desc_status_word_o;
  logic mac_loopback_i = 0, any_loopback_i = 0, rx_line_active_i = 0, tx_start_i = 0;
  logic defer_i = 0, first_attempt_i = 1, preamble_i = 0, sfd_done_i = 0, last_byte_i = 0;
  logic fifo_empty_i = 0, bus_granted_i = 1, size_mismatch_i = 0, mon_valid_i = 0;
  logic mon_crc_bad_i = 0, mon_align_err_i = 0, mon_sa_miss_i = 0, status_written_i = 0;
  logic carrier = 0, hit = 0, crs_i, collision_i, abort_o, backoff_o;
  logic append_fcs_o, rx_crc_enable_o, status_valid_o;
  int failures = 0, compares = 0, n_ab = 0, n_bo = 0, cyc = 0;
  always #10 clock_i = ~clock_i;
  // short counts keep the deferral and slot timers inside a brief run
  mtsf_top #(.DEFER_CYCLES(50), .SLOT_CYCLES(20)) u_dut (.*);
  mtsf_medium u_med (.clock_i, .carrier_i(carrier), .hit_i(hit), .crs_o(crs_i),
    .collision_o(collision_i));
  task automatic complete_run;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock_i) begin
    if (abort_o === 1'b1) n_ab++;
    if (backoff_o === 1'b1) n_bo++;
    cyc++;
    if (cyc > 6000) begin
      failures++;
      complete_run;
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    tick;
    reg_wr_i <= 0;
  endtask
  task automatic rdc(input logic [3:0] ad, input logic [15:0] m, input logic [15:0] e);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1;
    tick;
    reg_rd_i <= 0;
    @(negedge clock_i);
    chk(reg_rdata_o & m, e);
  endtask
  // descriptor write-back pulse; the block waits in done until it comes
  task automatic ack;
    @(posedge clock_i);
    status_written_i <= 1;
    tick;
    status_written_i <= 0;
  endtask
  // ev: 0 carrier, 1 defer, 2 underrun, 3 size mismatch, 4 late hit, 5 monitor, 6 loopback
  task automatic pkt(input logic [15:0] ctl, input logic [6:0] ev, input logic [2:0] mk,
    input int ncol, input logic [15:0] m, input logic [15:0] e);
    int k;
    begin : body
      wr(4'h0, ctl);
      mac_loopback_i <= ev[6];
      any_loopback_i <= ev[6];
      first_attempt_i <= 1;
      tx_start_i <= 1;
      defer_i <= ev[1];
      tick;
      tx_start_i <= 0;
      size_mismatch_i <= ev[3];
      tick;
      size_mismatch_i <= 0;
      defer_i <= 0;
      repeat (ncol) begin
        preamble_i <= 1;
        hit <= 1;
        tick;
        preamble_i <= 0;
        hit <= 0;
        first_attempt_i <= 0;
        tick(3);
      end
      if (ev[3] || ncol > 0) begin
        rdc(4'h0, m, e);
        ack;
        disable body;
      end
      for (int r = 0; r <= int'(ev[4]); r++) begin
        preamble_i <= 1;
        carrier <= ev[0];
        tick;
        preamble_i <= 0;
        if (ev[4]) tick(12);
        sfd_done_i <= 1;
        tick;
        sfd_done_i <= 0;
        if (r < int'(ev[4])) begin
          tick(12);
          hit <= 1;
          tick;
          hit <= 0;
          first_attempt_i <= 0;
          tick(3);
        end
      end
      fifo_empty_i <= ev[2];
      bus_granted_i <= !ev[2];
      mon_valid_i <= ev[5];
      {mon_crc_bad_i, mon_align_err_i, mon_sa_miss_i} <= mk;
      tick;
      fifo_empty_i <= 0;
      bus_granted_i <= 1;
      mon_valid_i <= 0;
      tick(2);
      if (ev[2]) begin
        rdc(4'h0, m, e);
        ack;
        disable body;
      end
      last_byte_i <= 1;
      tick;
      last_byte_i <= 0;
      carrier <= 0;
      for (k = 0; k < 20 && status_valid_o !== 1'b1; k++) @(negedge clock_i);
      chk(16'(status_valid_o), 16'h0001);
      chk(tx_desc_status_word_o & m, e);
      ack;
      rdc(4'h0, 16'h0220, 16'h0000);
      rdc(4'h2, m, e);
    end
    @(posedge clock_i);
    mac_loopback_i <= 0;
    any_loopback_i <= 0;
    carrier <= 0;
    $display("test done at %0t", $time);
  endtask
  initial begin
    tick(6);
    rst_n_i <= 1;
    rdc(4'h0, 16'hffff, 16'h0000);
    wr(4'h0, 16'hffff);
    rdc(4'h0, 16'hffff, 16'h7000);
    rdc(4'hf, 16'hffff, 16'h0000);
    rdc(4'h1, 16'hffff, 16'h0000);
    // a write while the clock enable is low must leave the control bits alone
    @(posedge clock_i);
    ce_i <= 0;
    wr(4'h0, 16'h0000);
    ce_i <= 1;
    rdc(4'h0, 16'hffff, 16'h7000);
    pkt(16'h0000, 7'h01, 3'h0, 0, 16'h07ff, 16'h0001);
    pkt(16'h0000, 7'h00, 3'h0, 0, 16'h07ff, 16'h0181);
    pkt(16'h0000, 7'h03, 3'h0, 0, 16'h07ff, 16'h0201);
    pkt(16'h0000, 7'h61, 3'h4, 0, 16'h07ff, 16'h0181);
    @(posedge clock_i);
    rx_line_active_i <= 1;
    pkt(16'h0000, 7'h41, 3'h0, 0, 16'h07ff, 16'h0081);
    rx_line_active_i <= 0;
    // no receive overrun is modelled, so monitored-bad always has meaning here
    for (int i = 0; i < 3; i++)
      pkt(16'h0000, 7'h21, 3'h1 << i, 0, 16'h07ff, 16'h0009);
    pkt(16'h2000, 7'h21, 3'h4, 0, 16'h07ff, 16'h0001);
    for (int s = 0; s < 2; s++)
      pkt(s ? 16'h4000 : 16'h0000, 7'h11, 3'h0, 0, 16'h07ff,
          s ? 16'h0021 : 16'h0001);
    pkt(16'h0000, 7'h02, 3'h0, 16, 16'h0243, 16'h0042);
    pkt(16'h0000, 7'h05, 3'h0, 0, 16'h0005, 16'h0004);
    pkt(16'h0000, 7'h08, 3'h0, 0, 16'h0003, 16'h0002);
    for (int d = 0; d < 2; d++) begin
      wr(4'h0, d ? 16'h1000 : 16'h0000);
      tx_start_i <= 1;
      defer_i <= 1;
      tick;
      tx_start_i <= 0;
      tick(60);
      defer_i <= 0;
      rdc(4'h0, 16'h0400, d ? 16'h0000 : 16'h0400);
      ack;
      $display("deferral test done at %0t", $time);
    end
    chk(16'(n_bo), 16'h0011);
    chk(16'(n_ab), 16'h0004);
    complete_run;
  end
endmodule
